// ---- pcg_peripheral_clock_gating.sv ----
/*
 Peripheral clock gating top: two module gating banks on a simple
 register port, registered run enables, gated peripheral clocks and
 per-peripheral register access blocking.
 Assumes one system clock, synchronous active-low reset and a bus
 master on the same clock that never issues read and write together.
*/
// The address-and-strobe port is this design's own decision.
// Functional notes
// [R1] Set disable bit stops that peripheral's clocks
// [R2] Disabled peripheral register writes ignored, reads invalid
// [R3] Run only if bit clear and present
// [R4] Both gating banks reset to zero
// [R5] Set bit disables one cycle later
// [R6] Cleared bit resumes one cycle later
// [R7] Serial port two bit always read/write
// [R8] Bank one bit positions as mapped
// [R9] Bank two bit positions as mapped
// [R10] Unimplemented bits read as zero
// [R11] Gate enables come from registered copies
module pcg_peripheral_clock_gating
   import pcg_pkg::*;
#(
   parameter logic [PCG_NUM_PERIPH-1:0] PRESENT = PCG_PRESENT_ALL
)(
   input wire logic I_CLK_SYS,
   input wire logic I_RST_N,
   input wire logic [15:0] i_ADDR,
   input wire logic [15:0] i_WDATA,
   input wire logic i_WR,
   input wire logic i_RD,
   input wire logic [PCG_NUM_PERIPH-1:0] i_PERIPH_WR,
   output logic [15:0] o_RDATA,
   output logic [PCG_NUM_PERIPH-1:0] o_RUN,
   output logic [PCG_NUM_PERIPH-1:0] o_PERIPH_WR,
   output logic [PCG_NUM_PERIPH-1:0] o_RDATA_VALID,
   output logic [PCG_NUM_PERIPH-1:0] o_GCLK
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   pcg_bus_req_t req;
   pcg_state_t st_reg;
   pcg_state_t st_next;
   logic [PCG_NUM_PERIPH-1:0] off_vec;

   assign req.addr = i_ADDR;
   assign req.wdata = i_WDATA;
   assign req.wr = i_WR;
   assign req.rd = i_RD;

   // ------------------------------------------------------------------
   // Disable bits gathered per peripheral
   // ------------------------------------------------------------------
   always_comb begin
      off_vec = '0;
      off_vec[PCG_EN_TIMER_THREE] = st_reg.gate_one_reg[PCG_TIMER_THREE_OFF_BIT]; // see [R8]
      off_vec[PCG_EN_TIMER_TWO] = st_reg.gate_one_reg[PCG_TIMER_TWO_OFF_BIT];
      off_vec[PCG_EN_TIMER_ONE] = st_reg.gate_one_reg[PCG_TIMER_ONE_OFF_BIT];
      off_vec[PCG_EN_TWO_WIRE_BUS] = st_reg.gate_one_reg[PCG_TWO_WIRE_BUS_OFF_BIT];
      off_vec[PCG_EN_SERIAL_PORT_TWO] = st_reg.gate_one_reg[PCG_SERIAL_PORT_TWO_OFF_BIT];
      off_vec[PCG_EN_SERIAL_PORT_ONE] = st_reg.gate_one_reg[PCG_SERIAL_PORT_ONE_OFF_BIT];
      off_vec[PCG_EN_SYNC_SERIAL] = st_reg.gate_one_reg[PCG_SYNC_SERIAL_OFF_BIT];
      off_vec[PCG_EN_CONVERTER] = st_reg.gate_one_reg[PCG_CONVERTER_OFF_BIT];
      off_vec[PCG_EN_CAPTURE_TWO] = st_reg.gate_two_reg[PCG_CAPTURE_TWO_OFF_BIT]; // see [R9]
      off_vec[PCG_EN_CAPTURE_ONE] = st_reg.gate_two_reg[PCG_CAPTURE_ONE_OFF_BIT];
      off_vec[PCG_EN_COMPARE_TWO] = st_reg.gate_two_reg[PCG_COMPARE_TWO_OFF_BIT];
      off_vec[PCG_EN_COMPARE_ONE] = st_reg.gate_two_reg[PCG_COMPARE_ONE_OFF_BIT];
   end

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.rdata_reg = '0;
      // Mask keeps unimplemented bits at zero; serial port two bit stays
      // writable even when that port is absent
      if (req.wr && req.addr == PCG_GATE_ONE_OFS) begin
         st_next.gate_one_reg = req.wdata & PCG_GATE_ONE_MASK; // see [R7] see [R10]
      end
      if (req.wr && req.addr == PCG_GATE_TWO_OFS) begin
         st_next.gate_two_reg = req.wdata & PCG_GATE_TWO_MASK; // see [R10]
      end
      if (req.rd) begin
         case (req.addr)
            PCG_GATE_ONE_OFS: st_next.rdata_reg = st_reg.gate_one_reg;
            PCG_GATE_TWO_OFS: st_next.rdata_reg = st_reg.gate_two_reg;
            default: st_next.rdata_reg = '0;
         endcase
      end
      // Run follows the stored bits one cycle after they change
      st_next.run_reg = ~off_vec & PRESENT; // see [R3] see [R5] see [R6] see [R11]
      if (!I_RST_N) begin
         st_next.gate_one_reg = PCG_GATE_ONE_RST; // see [R4]
         st_next.gate_two_reg = PCG_GATE_TWO_RST;
         st_next.run_reg = '0;
         st_next.rdata_reg = '0;
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      st_reg <= st_next;
   end

   // ------------------------------------------------------------------
   // Outputs and clock gates
   // ------------------------------------------------------------------
   assign o_RDATA = st_reg.rdata_reg;
   assign o_RUN = st_reg.run_reg;
   // Register access blocked while the module sleeps
   assign o_PERIPH_WR = i_PERIPH_WR & st_reg.run_reg; // see [R2]
   assign o_RDATA_VALID = st_reg.run_reg; // see [R2]

   genvar g;
   generate
      for (g = 0; g < PCG_NUM_PERIPH; g++) begin : g_gate
         // Enable is a flip-flop output, so the gate never sees a glitch
         pcg_clock_gate u_gate (
            .i_clk(I_CLK_SYS),
            .i_en(st_reg.run_reg[g]), // see [R1] see [R11]
            .o_gclk(o_GCLK[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   logic past_valid_reg;
   always_ff @(posedge I_CLK_SYS) begin
      past_valid_reg <= I_RST_N;
   end

   reset_zero_a: assert property (@(posedge I_CLK_SYS) // see [R4]
      !I_RST_N |=> (st_reg.gate_one_reg == 16'h0000 && st_reg.gate_two_reg == 16'h0000))
      else $error("gating banks not zero after reset");

   set_stops_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see [R5]
      (I_RST_N && i_WR && i_ADDR == PCG_GATE_ONE_OFS && i_WDATA[PCG_TIMER_ONE_OFF_BIT])
      |=> ##1 !o_RUN[PCG_EN_TIMER_ONE])
      else $error("timer one still running after disable");

   clear_runs_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see [R6]
      (i_WR && i_ADDR == PCG_GATE_TWO_OFS && !i_WDATA[PCG_COMPARE_ONE_OFF_BIT])
      ##1 I_RST_N |=> o_RUN[PCG_EN_COMPARE_ONE] == PRESENT[PCG_EN_COMPARE_ONE])
      else $error("compare one not resumed after clear");

   run_needs_present_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see [R3]
      (o_RUN & ~PRESENT) == '0)
      else $error("absent peripheral running");

   unimpl_zero_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see [R10]
      $past(i_RD) && $past(i_ADDR) == PCG_GATE_ONE_OFS |-> (o_RDATA & ~PCG_GATE_ONE_MASK) == '0)
      else $error("unimplemented bank one bit reads nonzero");

   port_two_bit_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see [R7]
      (i_WR && i_ADDR == PCG_GATE_ONE_OFS && i_WDATA[PCG_SERIAL_PORT_TWO_OFF_BIT])
      ##1 (i_RD && i_ADDR == PCG_GATE_ONE_OFS && !i_WR)
      |=> o_RDATA[PCG_SERIAL_PORT_TWO_OFF_BIT])
      else $error("serial port two bit did not read back one");

   write_block_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see [R2]
      !o_RUN[PCG_EN_CAPTURE_ONE] |-> !o_PERIPH_WR[PCG_EN_CAPTURE_ONE])
      else $error("write reached disabled capture one");

   bank_two_map_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see [R9]
      past_valid_reg && $stable(st_reg.gate_two_reg)
      |-> o_RUN[PCG_EN_CAPTURE_TWO] == (!st_reg.gate_two_reg[9] && PRESENT[PCG_EN_CAPTURE_TWO]))
      else $error("capture two enable mismatched to bit 9");

   // Sampled in the high phase, where an open gate would show a one
   gate_off_a: assert property (@(negedge I_CLK_SYS) disable iff (!I_RST_N) // see [R1]
      !o_RUN[PCG_EN_CONVERTER] && !$past(o_RUN[PCG_EN_CONVERTER])
      |-> !o_GCLK[PCG_EN_CONVERTER])
      else $error("converter clock toggles while disabled");

endmodule : pcg_peripheral_clock_gating

// ---- pcg_pkg.sv ----
/*
 Package for the peripheral clock gating block: register offsets, bit
 positions, reset values and the carrier types used by the top module.
 Assumes a 16-bit register port addressed by byte offsets.
*/
package pcg_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [15:0] PCG_GATE_ONE_OFS = 16'h0770;
   localparam logic [15:0] PCG_GATE_TWO_OFS = 16'h0772;
   localparam logic [15:0] PCG_GATE_ONE_RST = 16'h0000;
   localparam logic [15:0] PCG_GATE_TWO_RST = 16'h0000;

   // ------------------------------------------------------------------
   // Bank one bit positions
   // ------------------------------------------------------------------
   localparam int PCG_TIMER_THREE_OFF_BIT = 13;
   localparam int PCG_TIMER_TWO_OFF_BIT = 12;
   localparam int PCG_TIMER_ONE_OFF_BIT = 11;
   localparam int PCG_TWO_WIRE_BUS_OFF_BIT = 7;
   localparam int PCG_SERIAL_PORT_TWO_OFF_BIT = 6;
   localparam int PCG_SERIAL_PORT_ONE_OFF_BIT = 5;
   localparam int PCG_SYNC_SERIAL_OFF_BIT = 3;
   localparam int PCG_CONVERTER_OFF_BIT = 0;

   // ------------------------------------------------------------------
   // Bank two bit positions
   // ------------------------------------------------------------------
   localparam int PCG_CAPTURE_TWO_OFF_BIT = 9;
   localparam int PCG_CAPTURE_ONE_OFF_BIT = 8;
   localparam int PCG_COMPARE_TWO_OFF_BIT = 1;
   localparam int PCG_COMPARE_ONE_OFF_BIT = 0;

   // Implemented-bit masks, built from the positions above
   localparam logic [15:0] PCG_GATE_ONE_MASK = 16'((1 << PCG_TIMER_THREE_OFF_BIT)
      | (1 << PCG_TIMER_TWO_OFF_BIT) | (1 << PCG_TIMER_ONE_OFF_BIT)
      | (1 << PCG_TWO_WIRE_BUS_OFF_BIT) | (1 << PCG_SERIAL_PORT_TWO_OFF_BIT)
      | (1 << PCG_SERIAL_PORT_ONE_OFF_BIT) | (1 << PCG_SYNC_SERIAL_OFF_BIT)
      | (1 << PCG_CONVERTER_OFF_BIT));
   localparam logic [15:0] PCG_GATE_TWO_MASK = 16'((1 << PCG_CAPTURE_TWO_OFF_BIT)
      | (1 << PCG_CAPTURE_ONE_OFF_BIT) | (1 << PCG_COMPARE_TWO_OFF_BIT)
      | (1 << PCG_COMPARE_ONE_OFF_BIT));

   // Peripheral enable vector index
   localparam int PCG_NUM_PERIPH = 12;
   localparam int PCG_EN_TIMER_THREE = 0;
   localparam int PCG_EN_TIMER_TWO = 1;
   localparam int PCG_EN_TIMER_ONE = 2;
   localparam int PCG_EN_TWO_WIRE_BUS = 3;
   localparam int PCG_EN_SERIAL_PORT_TWO = 4;
   localparam int PCG_EN_SERIAL_PORT_ONE = 5;
   localparam int PCG_EN_SYNC_SERIAL = 6;
   localparam int PCG_EN_CONVERTER = 7;
   localparam int PCG_EN_CAPTURE_TWO = 8;
   localparam int PCG_EN_CAPTURE_ONE = 9;
   localparam int PCG_EN_COMPARE_TWO = 10;
   localparam int PCG_EN_COMPARE_ONE = 11;

   // Default: every peripheral present (variant straps narrow it)
   localparam logic [PCG_NUM_PERIPH-1:0] PCG_PRESENT_ALL = 12'hfff;

   // ------------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } pcg_bus_req_t;

   typedef struct packed {
      logic [15:0] gate_one_reg;
      logic [15:0] gate_two_reg;
      logic [PCG_NUM_PERIPH-1:0] run_reg;
      logic [15:0] rdata_reg;
   } pcg_state_t;

endpackage : pcg_pkg

// ---- pcg_clock_gate.sv ----
/*
 Glitch-free clock gate cell for one peripheral clock.
 Assumes the enable changes only right after a rising edge of the clock.
*/
module pcg_clock_gate
   import pcg_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_en,
   output logic o_gclk
);

   // ------------------------------------------------------------------
   // Latch while the clock is low
   // ------------------------------------------------------------------
   logic en_latch;

   // Transparent low latch keeps the gated pulse whole
   always_latch begin
      if (!i_clk) begin
         en_latch = i_en;
      end
   end

   assign o_gclk = i_clk & en_latch;

endmodule : pcg_clock_gate

// ---- tb.sv ----
/*
 Self-checking bench for the peripheral clock gating top: reset and idle-bus checks, then a table
 of register writes with readback and run-enable checks, then a mid-run reset case.
 Assumes the register port contract of the design package and one clock.
*/
module tb
   import pcg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------------
   // Harness
   // ------------------------------------------------------------------
   // Serial port two left out of this variant
   localparam logic [11:0] PRES = 12'hfef;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [11:0] pwr = 12'h5a5;
   logic [15:0] rdata;
   logic [11:0] run, owr, vld, gclk;
   logic [15:0] b1 = 16'h0000;
   logic [15:0] b2 = 16'h0000;
   logic [15:0] got;
   logic [11:0] prev;
   int fails = 0;
   int compares = 0;
   // Address, write data, expected readback
   logic [47:0] rows [12] = '{48'h0770_ffff_38e9, 48'h0772_ffff_0303, 48'h0770_0800_0800,
      48'h0770_1000_1000, 48'h0770_2000_2000, 48'h0770_00a8_00a8, 48'h0770_0041_0041,
      48'h0772_0202_0202, 48'h0772_0101_0101, 48'h0770_c716_0000, 48'h1234_ffff_0000,
      48'h0772_fcfc_0000};

   pcg_peripheral_clock_gating #(.PRESENT(PRES)) u_pcg_peripheral_clock_gating (
      .I_CLK_SYS(clk), .I_RST_N(rst_n), .i_ADDR(addr), .i_WDATA(wdata), .i_WR(wr),
      .i_RD(rd), .i_PERIPH_WR(pwr), .o_RDATA(rdata), .o_RUN(run), .o_PERIPH_WR(owr),
      .o_RDATA_VALID(vld), .o_GCLK(gclk));

   initial begin
      forever #4 clk = ~clk;
   end

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [11:0] exp_run(input logic [15:0] a, input logic [15:0] b);
      logic [11:0] off;
      off = {b[0], b[1], b[8], b[9], a[0], a[3], a[5], a[6], a[7], a[11], a[12], a[13]};
      return ~off & PRES;
   endfunction : exp_run

   task automatic cmp16(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : cmp16

   task automatic cmp12(input string n, input logic [11:0] e, input logic [11:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : cmp12

   // Called while the clock is high, so open gates show as ones
   task automatic chk_run(input logic [11:0] e);
      cmp12("run", e, run);
      cmp12("valid", e, vld);
      cmp12("periph_wr", pwr & e, owr);
      cmp12("gclk", e, gclk);
   endtask : chk_run

   task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : bus_wr

   task automatic bus_rd(input logic [15:0] a, output logic [15:0] g);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 g = rdata;
   endtask : bus_rd

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report

   // ------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------
   initial begin
      #40000;
      fails++;
      final_report();
   end

   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      bus_rd(16'h0770, got);
      cmp16("bank one reset", 16'h0000, got);
      bus_rd(16'h0772, got);
      cmp16("bank two reset", 16'h0000, got);
      chk_run(PRES);
      @(posedge clk);
      #1 cmp16("idle rdata", 16'h0000, rdata);
      $display("Test reset values done");
      // Run still old at the write edge, new one edge later
      foreach (rows[i]) begin
         pwr <= ~pwr;
         prev = exp_run(b1, b2);
         bus_wr(rows[i][47:32], rows[i][31:16]);
         #1 chk_run(prev);
         bus_rd(rows[i][47:32], got);
         cmp16("readback", rows[i][15:0], got);
         if (rows[i][47:32] == 16'h0770)
            b1 = rows[i][15:0];
         else if (rows[i][47:32] == 16'h0772)
            b2 = rows[i][15:0];
         @(posedge clk);
         #1 chk_run(exp_run(b1, b2));
      end
      $display("Test register table done");
      // Reset in mid-run with every disable set
      bus_wr(16'h0770, 16'hffff);
      bus_wr(16'h0772, 16'hffff);
      repeat (2) @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk_run(12'h000);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk_run(PRES);
      bus_rd(16'h0770, got);
      cmp16("bank one rerun", 16'h0000, got);
      bus_rd(16'h0772, got);
      cmp16("bank two rerun", 16'h0000, got);
      $display("Test mid-run reset done");
      final_report();
   end

endmodule : tb
